/* core/sfcs_pkg.sv */
// package: register map, field layouts, states and helpers for the serial format/clock select unit
package sfcs_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W   = 3;
	localparam int          DATA_W   = 8;
	localparam logic [2:0]  OFS_MODE = 3'h0;
	localparam logic [2:0]  OFS_CTRL = 3'h1;
	localparam logic [2:0]  OFS_BRR  = 3'h2;
	localparam logic [2:0]  OFS_TDR  = 3'h3;
	localparam logic [2:0]  OFS_STAT = 3'h4;
	localparam logic [2:0]  OFS_RDR  = 3'h5;

	localparam logic [7:0]  MODE_RST   = 8'h00;
	localparam logic [7:0]  MODE_WMASK = 8'hfc;
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [7:0]  CTRL_WMASK = 8'h33;
	localparam logic [7:0]  BRR_RST    = 8'hff;
	localparam logic [7:0]  STAT_RST   = 8'h84;
	localparam logic [7:0]  DATA_RST   = 8'h00;

	// ----------------------------------------------------------------
	// timing: sixteen ticks per bit
	// ----------------------------------------------------------------
	localparam logic [3:0]  PH_SAMPLE  = 4'h7;
	localparam logic [3:0]  PH_HALF    = 4'h8;
	localparam logic [3:0]  PH_LAST    = 4'hf;
	localparam logic [3:0]  DATA_LEN8  = 4'h8;
	localparam logic [3:0]  DATA_LEN7  = 4'h7;
	localparam logic [7:0]  MASK7      = 8'h7f;

	// ----------------------------------------------------------------
	// field layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       sync_select;
		logic       char_length_select;
		logic       parity_enable;
		logic       parity_odd_select;
		logic       two_stop_select;
		logic       multiproc_format_select;
		logic [1:0] rsv;
	} sfcs_mode_t;

	typedef struct packed {
		logic [1:0] rsv_hi;
		logic       tx_enable_bit;
		logic       rx_enable_bit;
		logic [1:0] rsv_lo;
		logic       clock_select_hi;
		logic       clock_select_lo;
	} sfcs_ctrl_t;

	typedef struct packed {
		logic tx_empty;
		logic rx_full;
		logic overrun_error_flag;
		logic framing_err;
		logic parity_err;
		logic tx_end;
		logic multiproc_bit;
		logic multiproc_bit_tx;
	} sfcs_stat_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} sfcs_tx_st_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} sfcs_rx_st_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] sfcs_data_len(input sfcs_mode_t m);
		return (m.sync_select | ~m.char_length_select) ? DATA_LEN8 : DATA_LEN7;
	endfunction : sfcs_data_len

	function automatic logic sfcs_parity(input logic [7:0] d, input sfcs_mode_t m);
		logic [7:0] md;
		md = (sfcs_data_len(m) == DATA_LEN7) ? (d & MASK7) : d;
		return (^md) ^ m.parity_odd_select;
	endfunction : sfcs_parity

endpackage : sfcs_pkg

/* core/sfcs_core.sv */
// serial communication unit: format and clock source select, async/sync framing, double buffering
//
// Contract
// - sync mode always moves eight data bits
// - sync receive flags overrun in overrun flag
// - sync internal clock: generator runs, clock driven out
// - sync external clock: shift on clock pin edges
// - sync select ignores length, parity, stop bits
// - async: 7/8 bits, parity option, 1/2 stops
// - multiprocessor format replaces parity with flag bit
// - clock source from sync bit and selects
// - async external clock is sixteen times bit rate
// - async internal: pin unused or bit-rate clock
// - sync internal drives clock regardless of low select
// - async characters framed individually start to stop
// - transmit and receive run independently
// - both directions double buffered
// - line idles high; falling edge starts character
// - order: start, data LSB first, parity, stops
// - receiver aligns to start bit falling edge
// - sample each bit at eighth tick
`timescale 1ns/1ps

module sfcs_core (
	input  wire logic                     ref_clk_i,  // 10 MHz system clock
	input  wire logic                     sys_rst_i,  // synchronous reset, active high
	input  wire logic [sfcs_pkg::ADDR_W-1:0] addr_i,  // register address
	input  wire logic [sfcs_pkg::DATA_W-1:0] wdata_i, // write data
	input  wire logic                     wr_i,       // write strobe
	input  wire logic                     rd_i,       // read strobe
	output logic      [sfcs_pkg::DATA_W-1:0] rdata_o, // read data, cycle after rd_i
	input  wire logic                     rxd_i,      // serial receive data
	output logic                          txd_o,      // serial transmit data
	input  wire logic                     sck_i,      // serial clock pin, input level
	output logic                          sck_o,      // serial clock pin, output level
	output logic                          sck_oe_o    // serial clock pin, output enable
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	sfcs_pkg::sfcs_mode_t mode_q, mode_d;
	sfcs_pkg::sfcs_ctrl_t ctrl_q, ctrl_d;
	sfcs_pkg::sfcs_stat_t stat_q, stat_d;
	logic [7:0]           brr_q, brr_d;
	logic [7:0]           tdr_q, tdr_d;
	logic [7:0]           rdr_q, rdr_d;
	logic [7:0]           rdata_q, rdata_d;

	// events from the datapaths
	logic       tx_load, tx_done;
	logic       rx_done, rx_ovr, rx_fer, rx_per, rx_mpb;
	logic [7:0] rx_data;

	always_comb begin
		mode_d  = mode_q;
		ctrl_d  = ctrl_q;
		brr_d   = brr_q;
		tdr_d   = tdr_q;
		rdr_d   = rdr_q;
		stat_d  = stat_q;
		rdata_d = '0;
		if (wr_i) begin
			unique case (addr_i)
				sfcs_pkg::OFS_MODE: mode_d = sfcs_pkg::sfcs_mode_t'(wdata_i & sfcs_pkg::MODE_WMASK);
				sfcs_pkg::OFS_CTRL: ctrl_d = sfcs_pkg::sfcs_ctrl_t'(wdata_i & sfcs_pkg::CTRL_WMASK);
				sfcs_pkg::OFS_BRR:  brr_d  = wdata_i;
				sfcs_pkg::OFS_TDR: begin
					tdr_d           = wdata_i;
					stat_d.tx_empty = 1'b0;
					stat_d.tx_end   = 1'b0;
				end
				sfcs_pkg::OFS_STAT: begin
					stat_d.overrun_error_flag = stat_q.overrun_error_flag & wdata_i[5];
					stat_d.framing_err        = stat_q.framing_err & wdata_i[4];
					stat_d.parity_err         = stat_q.parity_err & wdata_i[3];
					stat_d.multiproc_bit_tx   = wdata_i[0];
				end
				default: ;
			endcase
		end
		if (rd_i) begin
			unique case (addr_i)
				sfcs_pkg::OFS_MODE: rdata_d = mode_q;
				sfcs_pkg::OFS_CTRL: rdata_d = ctrl_q;
				sfcs_pkg::OFS_BRR:  rdata_d = brr_q;
				sfcs_pkg::OFS_TDR:  rdata_d = tdr_q;
				sfcs_pkg::OFS_STAT: rdata_d = stat_q;
				sfcs_pkg::OFS_RDR: begin
					rdata_d        = rdr_q;
					stat_d.rx_full = 1'b0;
				end
				default: rdata_d = '0;
			endcase
		end
		// hardware sets after software clears, so a coinciding event wins
		if (tx_load || !ctrl_q.tx_enable_bit)
			stat_d.tx_empty = 1'b1;
		if (tx_done)
			stat_d.tx_end = 1'b1;
		if (rx_done) begin
			if (rx_ovr)
				stat_d.overrun_error_flag = 1'b1;
			else if (rx_fer)
				stat_d.framing_err = 1'b1;
			else if (rx_per)
				stat_d.parity_err = 1'b1;
			else begin
				rdr_d                = rx_data;
				stat_d.rx_full       = 1'b1;
				stat_d.multiproc_bit = rx_mpb;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mode_q  <= sfcs_pkg::sfcs_mode_t'(sfcs_pkg::MODE_RST);
			ctrl_q  <= sfcs_pkg::sfcs_ctrl_t'(sfcs_pkg::CTRL_RST);
			stat_q  <= sfcs_pkg::sfcs_stat_t'(sfcs_pkg::STAT_RST);
			brr_q   <= sfcs_pkg::BRR_RST;
			tdr_q   <= sfcs_pkg::DATA_RST;
			rdr_q   <= sfcs_pkg::DATA_RST;
			rdata_q <= sfcs_pkg::DATA_RST;
		end else begin
			mode_q  <= mode_d;
			ctrl_q  <= ctrl_d;
			stat_q  <= stat_d;
			brr_q   <= brr_d;
			tdr_q   <= tdr_d;
			rdr_q   <= rdr_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

	// ----------------------------------------------------------------
	// clock source, baud generator, phase
	// ----------------------------------------------------------------
	logic       sync_m, ext_clk;
	logic [7:0] brg_q, brg_d;
	logic [3:0] ph_q, ph_d;
	logic       sck_prev_q, rxd_prev_q;
	logic       brg_tick, ext_rise, ext_fall, tick16, sclk_run, sfall, srise;
	logic       tx_busy, rx_sync_on;

	assign sync_m   = mode_q.sync_select;
	assign ext_clk  = ctrl_q.clock_select_hi;
	// compare with >= so a lowered rate setting restarts the count at once instead of wrapping
	assign brg_tick = !ext_clk && (brg_q >= brr_q);
	assign ext_rise = sck_i && !sck_prev_q;
	assign ext_fall = !sck_i && sck_prev_q;
	assign tick16   = ext_clk ? ext_rise : brg_tick;
	assign sclk_run = tx_busy || rx_sync_on;
	assign sfall    = ext_clk ? ext_fall : (brg_tick && sclk_run && ph_q == '0);
	assign srise    = ext_clk ? ext_rise : (brg_tick && sclk_run && ph_q == sfcs_pkg::PH_HALF);

	always_comb begin
		brg_d = (ext_clk || brg_tick) ? '0 : brg_q + 8'h01;
		ph_d  = ph_q;
		if (sync_m && !sclk_run)
			ph_d = '0;
		else if (tick16)
			ph_d = ph_q + 4'h1;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			brg_q      <= '0;
			ph_q       <= '0;
			sck_prev_q <= 1'b1;
			rxd_prev_q <= 1'b1;
		end else begin
			brg_q      <= brg_d;
			ph_q       <= ph_d;
			sck_prev_q <= sck_i;
			rxd_prev_q <= rxd_i;
		end
	end

	// sync internal: low first half, rising mid-bit; async 01: bit-rate clock rising at bit centre
	assign sck_oe_o = !ext_clk && (sync_m || ctrl_q.clock_select_lo);
	assign sck_o    = (sync_m && !sclk_run) ? 1'b1 : ph_q[3];

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	sfcs_pkg::sfcs_tx_st_t tx_st_q, tx_st_d;
	logic [7:0] tsr_q, tsr_d;
	logic [3:0] tcnt_q, tcnt_d;
	logic       tpar_q, tpar_d, tstop_q, tstop_d, txd_q, txd_d;
	logic       tx_adv, tx_go;
	logic [3:0] len;

	assign len     = sfcs_pkg::sfcs_data_len(mode_q);
	assign tx_adv  = tick16 && ph_q == sfcs_pkg::PH_LAST;
	assign tx_go   = ctrl_q.tx_enable_bit && !stat_q.tx_empty;
	assign tx_busy = tx_st_q != sfcs_pkg::TX_IDLE;

	always_comb begin
		tx_st_d = tx_st_q;
		tsr_d   = tsr_q;
		tcnt_d  = tcnt_q;
		tpar_d  = tpar_q;
		tstop_d = tstop_q;
		txd_d   = txd_q;
		tx_load = 1'b0;
		tx_done = 1'b0;
		if (!ctrl_q.tx_enable_bit) begin
			tx_st_d = sfcs_pkg::TX_IDLE;
			txd_d   = 1'b1;
		end else if (sync_m) begin
			if (tx_st_q == sfcs_pkg::TX_IDLE && tx_go) begin
				tx_load = 1'b1;
				tsr_d   = tdr_q;
				tcnt_d  = '0;
				tx_st_d = sfcs_pkg::TX_DATA;
			end else if (tx_st_q == sfcs_pkg::TX_DATA) begin
				if (sfall) begin
					txd_d = tsr_q[0];
					tsr_d = tsr_q >> 1;
				end
				if (srise) begin
					tcnt_d = tcnt_q + 4'h1;
					if (tcnt_q == sfcs_pkg::DATA_LEN8 - 4'h1) begin
						tcnt_d = '0;
						if (tx_go) begin
							tx_load = 1'b1;
							tsr_d   = tdr_q;
						end else begin
							tx_done = 1'b1;
							tx_st_d = sfcs_pkg::TX_IDLE;
						end
					end
				end
			end
		end else if (tx_adv) begin
			unique case (tx_st_q)
				sfcs_pkg::TX_IDLE: begin
					txd_d = 1'b1;
					if (tx_go) begin
						tx_load = 1'b1;
						tsr_d   = tdr_q;
						tpar_d  = mode_q.multiproc_format_select ? stat_q.multiproc_bit_tx
						                                         : sfcs_pkg::sfcs_parity(tdr_q, mode_q);
						tx_st_d = sfcs_pkg::TX_START;
						txd_d   = 1'b0;
					end
				end
				sfcs_pkg::TX_START, sfcs_pkg::TX_DATA: begin
					if (tx_st_q == sfcs_pkg::TX_START || tcnt_q != len) begin
						txd_d   = tsr_q[0];
						tsr_d   = tsr_q >> 1;
						tcnt_d  = (tx_st_q == sfcs_pkg::TX_START) ? 4'h1 : tcnt_q + 4'h1;
						tx_st_d = sfcs_pkg::TX_DATA;
					end else if (mode_q.parity_enable || mode_q.multiproc_format_select) begin
						txd_d   = tpar_q;
						tx_st_d = sfcs_pkg::TX_PAR;
					end else begin
						txd_d   = 1'b1;
						tstop_d = 1'b0;
						tx_st_d = sfcs_pkg::TX_STOP;
					end
				end
				sfcs_pkg::TX_PAR: begin
					txd_d   = 1'b1;
					tstop_d = 1'b0;
					tx_st_d = sfcs_pkg::TX_STOP;
				end
				sfcs_pkg::TX_STOP: begin
					if (mode_q.two_stop_select && !tstop_q)
						tstop_d = 1'b1;
					else if (tx_go) begin
						tx_load = 1'b1;
						tsr_d   = tdr_q;
						tpar_d  = mode_q.multiproc_format_select ? stat_q.multiproc_bit_tx
						                                         : sfcs_pkg::sfcs_parity(tdr_q, mode_q);
						txd_d   = 1'b0;
						tx_st_d = sfcs_pkg::TX_START;
					end else begin
						tx_done = 1'b1;
						tx_st_d = sfcs_pkg::TX_IDLE;
					end
				end
				default: tx_st_d = sfcs_pkg::TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tx_st_q <= sfcs_pkg::TX_IDLE;
			tsr_q   <= '0;
			tcnt_q  <= '0;
			tpar_q  <= 1'b0;
			tstop_q <= 1'b0;
			txd_q   <= 1'b1;
		end else begin
			tx_st_q <= tx_st_d;
			tsr_q   <= tsr_d;
			tcnt_q  <= tcnt_d;
			tpar_q  <= tpar_d;
			tstop_q <= tstop_d;
			txd_q   <= txd_d;
		end
	end

	assign txd_o = txd_q;

	// ----------------------------------------------------------------
	// receiver, independent of the transmitter
	// ----------------------------------------------------------------
	sfcs_pkg::sfcs_rx_st_t rx_st_q, rx_st_d;
	logic [7:0] rsr_q, rsr_d;
	logic [3:0] rsub_q, rsub_d, rcnt_q, rcnt_d;
	logic       rpar_q, rpar_d;
	logic       rx_err, start_edge, rx_samp;

	assign rx_err     = stat_q.overrun_error_flag || stat_q.framing_err || stat_q.parity_err;
	assign rx_sync_on = sync_m && ctrl_q.rx_enable_bit && !rx_err;
	assign start_edge = rxd_prev_q && !rxd_i;
	assign rx_samp    = tick16 && rsub_q == sfcs_pkg::PH_SAMPLE;

	always_comb begin
		rx_st_d = rx_st_q;
		rsr_d   = rsr_q;
		rsub_d  = tick16 ? rsub_q + 4'h1 : rsub_q;
		rcnt_d  = rcnt_q;
		rpar_d  = rpar_q;
		rx_done = 1'b0;
		rx_ovr  = stat_q.rx_full;
		rx_fer  = 1'b0;
		rx_per  = 1'b0;
		rx_mpb  = 1'b0;
		rx_data = (len == sfcs_pkg::DATA_LEN7) ? (rsr_q >> 1) : rsr_q;
		if (!ctrl_q.rx_enable_bit || (sync_m && rx_err)) begin
			rx_st_d = sfcs_pkg::RX_IDLE;
			rcnt_d  = '0;
		end else if (sync_m) begin
			rx_st_d = sfcs_pkg::RX_IDLE;
			if (srise) begin
				rsr_d  = {rxd_i, rsr_q[7:1]};
				rcnt_d = rcnt_q + 4'h1;
				if (rcnt_q == sfcs_pkg::DATA_LEN8 - 4'h1) begin
					rcnt_d  = '0;
					rx_done = 1'b1;
					rx_data = {rxd_i, rsr_q[7:1]};
				end
			end
		end else begin
			unique case (rx_st_q)
				sfcs_pkg::RX_IDLE: begin
					if (start_edge && !rx_err) begin
						rsub_d  = '0;
						rx_st_d = sfcs_pkg::RX_START;
					end
				end
				sfcs_pkg::RX_START: begin
					if (rx_samp) begin
						rcnt_d  = '0;
						rx_st_d = rxd_i ? sfcs_pkg::RX_IDLE : sfcs_pkg::RX_DATA;
					end
				end
				sfcs_pkg::RX_DATA: begin
					if (rx_samp) begin
						rsr_d  = {rxd_i, rsr_q[7:1]};
						rcnt_d = rcnt_q + 4'h1;
						if (rcnt_q == len - 4'h1)
							rx_st_d = (mode_q.parity_enable || mode_q.multiproc_format_select)
							          ? sfcs_pkg::RX_PAR : sfcs_pkg::RX_STOP;
					end
				end
				sfcs_pkg::RX_PAR: begin
					if (rx_samp) begin
						rpar_d  = rxd_i;
						rx_st_d = sfcs_pkg::RX_STOP;
					end
				end
				sfcs_pkg::RX_STOP: begin
					if (rx_samp) begin
						rx_done = 1'b1;
						rx_fer  = !rxd_i;
						rx_per  = mode_q.parity_enable && !mode_q.multiproc_format_select
						          && (rpar_q != sfcs_pkg::sfcs_parity(rx_data, mode_q));
						rx_mpb  = mode_q.multiproc_format_select && rpar_q;
						rx_st_d = sfcs_pkg::RX_IDLE;
					end
				end
				default: rx_st_d = sfcs_pkg::RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_st_q <= sfcs_pkg::RX_IDLE;
			rsr_q   <= '0;
			rsub_q  <= '0;
			rcnt_q  <= '0;
			rpar_q  <= 1'b0;
		end else begin
			rx_st_q <= rx_st_d;
			rsr_q   <= rsr_d;
			rsub_q  <= rsub_d;
			rcnt_q  <= rcnt_d;
			rpar_q  <= rpar_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_sync_clk_drive: assert property (sync_m && !ext_clk |-> sck_oe_o)
		else $error("sync internal clock not driven");
	a_ext_clk_input: assert property (ext_clk |-> !sck_oe_o && !brg_tick)
		else $error("clock pin driven or generator used with external clock");
	a_async_pin_off: assert property (!sync_m && !ext_clk && !ctrl_q.clock_select_lo |-> !sck_oe_o)
		else $error("clock pin driven in async 00");
	a_start_bit_low: assert property ($rose(tx_st_q == sfcs_pkg::TX_START) |-> !txd_o)
		else $error("start bit not low");
	a_idle_mark: assert property (!ctrl_q.tx_enable_bit |=> txd_o)
		else $error("line not at mark with transmitter off");
	a_rx_restart: assert property (!sync_m && ctrl_q.rx_enable_bit && !rx_err && rx_st_q == sfcs_pkg::RX_IDLE
		&& start_edge |=> rx_st_q == sfcs_pkg::RX_START && rsub_q == '0)
		else $error("start edge did not restart oversampling");
	a_sync_overrun: assert property (rx_done && stat_q.rx_full |=> stat_q.overrun_error_flag && $stable(rdr_q))
		else $error("overrun not flagged");
	a_sync_eight: assert property (sync_m && rx_done |-> rcnt_q == sfcs_pkg::DATA_LEN8 - 4'h1)
		else $error("sync character not eight bits");
	a_mp_no_parity: assert property (mode_q.multiproc_format_select |-> !rx_per)
		else $error("parity checked in multiprocessor format");

	c_async_rx_done: cover property (!sync_m && rx_done && !rx_ovr && !rx_fer);
	c_sync_tx_done: cover property (sync_m && tx_done);
	c_back_to_back: cover property (tx_st_q == sfcs_pkg::TX_STOP && tx_load);

endmodule : sfcs_core

/* sim/sfcs_remote.sv */
// remote serial device model: async/sync frame source and clock source for the unit's pin
`timescale 1ns/1ps

module sfcs_remote (
	input  wire logic clk_i,    // system clock
	output logic      rxd_o,    // line into the unit
	output logic      sck_o,    // clock level offered on the pin
	output logic      sck_oe_o  // high while this model drives the pin
);
	logic ext_run;  // free-running 16x clock requested

	initial begin
		rxd_o = 1'b1;
		sck_o = 1'b1;
		sck_oe_o = 1'b0;
		ext_run = 1'b0;
	end

	// ----------------------------------------------------------------
	// clock source: runs free once started, never paused mid-character
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (ext_run) begin
			sck_o <= ~sck_o;
		end
	end

	task automatic ext(input logic on);
		@(posedge clk_i);
		ext_run <= on;
		sck_oe_o <= on;
	endtask : ext

	task automatic send_async(input logic [7:0] d, input int nb, input int per);
		@(posedge clk_i);
		rxd_o <= 1'b0;
		repeat (per) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			rxd_o <= d[i];
			repeat (per) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
		repeat (per) @(posedge clk_i);
	endtask : send_async

	task automatic send_sync(input logic [7:0] d);
		sck_oe_o <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			sck_o <= 1'b0;
			rxd_o <= d[i];
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b1;
			repeat (3) @(posedge clk_i);
		end
		@(posedge clk_i);
		rxd_o <= ~d[7];
	endtask : send_sync
endmodule : sfcs_remote

/* sim/test_sfcs_core.sv */
// self-checking bench for the serial format and clock select unit
`timescale 1ns/1ps

module test_sfcs_core;
	logic       ref_clk_i;
	logic       sys_rst_i;
	logic [2:0] addr_i;
	logic [7:0] wdata_i;
	logic       wr_i;
	logic       rd_i;
	logic [7:0] rdata_o;
	logic       rxd;
	logic       txd_o;
	logic       dut_sck;
	logic       dut_sck_oe;
	logic       rem_sck;
	logic       rem_sck_oe;
	logic       sck_pin;
	int         mismatches = 0;
	int         comparisons = 0;
	int         cycles = 0;

	// pin level from both parties' enables; undriven pin floats to an arbitrary high
	assign sck_pin = dut_sck_oe ? dut_sck : (rem_sck_oe ? rem_sck : 1'b1);

	sfcs_core dut_u (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.addr_i   (addr_i),
		.wdata_i  (wdata_i),
		.wr_i     (wr_i),
		.rd_i     (rd_i),
		.rdata_o  (rdata_o),
		.rxd_i    (rxd),
		.txd_o    (txd_o),
		.sck_i    (sck_pin),
		.sck_o    (dut_sck),
		.sck_oe_o (dut_sck_oe)
	);

	sfcs_remote rem_u (
		.clk_i   (ref_clk_i),
		.rxd_o   (rxd),
		.sck_o   (rem_sck),
		.sck_oe_o(rem_sck_oe)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr_reg

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		check(nm, {8'h00, rdata_o & m}, {8'h00, e});
	endtask : rd_chk

	// waits for a start bit on the transmit line, then samples each bit at its centre
	task automatic grab(input int nb, input int per, output logic [15:0] f);
		int w;
		w = 0;
		f = 16'h0000;
		while (txd_o !== 1'b0 && w < 4000) begin
			@(posedge ref_clk_i);
			#1;
			w++;
		end
		repeat (per / 2) @(posedge ref_clk_i);
		#1;
		for (int i = 0; i < nb; i++) begin
			f[i] = txd_o;
			repeat (per) @(posedge ref_clk_i);
			#1;
		end
	endtask : grab

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] f;
		int          n;
		logic        p;
		sys_rst_i = 1'b1;
		addr_i = 3'h0;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd_chk(sfcs_pkg::OFS_MODE, 8'hff, 8'h00, "mode reset");
		rd_chk(sfcs_pkg::OFS_BRR, 8'hff, 8'hff, "brr reset");
		rd_chk(sfcs_pkg::OFS_STAT, 8'hff, 8'h84, "status reset");
		rd_chk(3'h6, 8'hff, 8'h00, "unmapped read");
		$display("test reset done");
		wr_reg(sfcs_pkg::OFS_BRR, 8'h00);
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h30);
		fork
			begin
				wr_reg(sfcs_pkg::OFS_TDR, 8'ha5);
				grab(10, 16, f);
			end
			rem_u.send_async(8'h3c, 8, 16);
		join
		check("frame 8n1", f, {6'h00, 1'b1, 8'ha5, 1'b0});
		rd_chk(sfcs_pkg::OFS_STAT, 8'h40, 8'h40, "rx full");
		rd_chk(sfcs_pkg::OFS_RDR, 8'hff, 8'h3c, "rx data");
		rd_chk(sfcs_pkg::OFS_STAT, 8'h40, 8'h00, "rx full cleared");
		$display("test duplex done");
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h00);
		wr_reg(sfcs_pkg::OFS_MODE, 8'h68);
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h20);
		wr_reg(sfcs_pkg::OFS_TDR, 8'hcb);
		grab(11, 16, f);
		check("frame 7e2", f, {5'h00, 1'b1, 1'b1, ^7'h4b, 7'h4b, 1'b0});
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h00);
		wr_reg(sfcs_pkg::OFS_MODE, 8'h24);
		wr_reg(sfcs_pkg::OFS_STAT, 8'h01);
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h20);
		wr_reg(sfcs_pkg::OFS_TDR, 8'h00);
		grab(11, 16, f);
		check("frame mp", f, {5'h00, 1'b1, 1'b1, 8'h00, 1'b0});
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h00);
		wr_reg(sfcs_pkg::OFS_MODE, 8'h70);
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h10);
		rem_u.send_async(8'h01, 8, 16);
		rd_chk(sfcs_pkg::OFS_RDR, 8'hff, 8'h01, "rx 7o1 data");
		rem_u.send_async(8'h81, 8, 16);
		rd_chk(sfcs_pkg::OFS_STAT, 8'h78, 8'h08, "parity error");
		wr_reg(sfcs_pkg::OFS_STAT, 8'h00);
		$display("test formats done");
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h00);
		wr_reg(sfcs_pkg::OFS_MODE, 8'h00);
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h22);
		rem_u.ext(1'b1);
		wr_reg(sfcs_pkg::OFS_TDR, 8'h5a);
		grab(10, 32, f);
		check("frame ext clock", f, {6'h00, 1'b1, 8'h5a, 1'b0});
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h00);
		rem_u.ext(1'b0);
		$display("test external clock done");
		for (int i = 0; i < 8; i++) begin
			wr_reg(sfcs_pkg::OFS_MODE, {i[2], 7'h00});
			wr_reg(sfcs_pkg::OFS_CTRL, {6'h00, i[1:0]});
			repeat (2) @(posedge ref_clk_i);
			#1;
			check("pin drive", {15'h0000, dut_sck_oe}, {15'h0000, ~i[1] & (i[2] | i[0])});
		end
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h00);
		wr_reg(sfcs_pkg::OFS_MODE, 8'hbc);
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h20);
		wr_reg(sfcs_pkg::OFS_TDR, 8'h96);
		f = 16'h0000;
		n = 0;
		p = dut_sck;
		repeat (200) begin
			@(posedge ref_clk_i);
			#1;
			if (dut_sck && !p) begin
				f[n[3:0]] = txd_o;
				n++;
			end
			p = dut_sck;
		end
		check("sync tx data", f, 16'h0096);
		check("sync tx clocks", n[15:0], 16'h0008);
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h00);
		wr_reg(sfcs_pkg::OFS_MODE, 8'h80);
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h10);
		#1;
		p = dut_sck;
		n = 0;
		repeat (64) begin
			@(posedge ref_clk_i);
			#1;
			if (dut_sck && !p) begin
				n++;
			end
			p = dut_sck;
		end
		check("sync clock rises", n[15:0], 16'h0004);
		$display("test clock pin done");
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h00);
		wr_reg(sfcs_pkg::OFS_MODE, 8'hc8);
		wr_reg(sfcs_pkg::OFS_CTRL, 8'h12);
		rem_u.send_sync(8'h81);
		repeat (4) @(posedge ref_clk_i);
		rd_chk(sfcs_pkg::OFS_STAT, 8'h60, 8'h40, "sync rx full");
		rem_u.send_sync(8'h7e);
		repeat (4) @(posedge ref_clk_i);
		rd_chk(sfcs_pkg::OFS_STAT, 8'h20, 8'h20, "overrun");
		rd_chk(sfcs_pkg::OFS_RDR, 8'hff, 8'h81, "sync data");
		wr_reg(sfcs_pkg::OFS_STAT, 8'h00);
		rd_chk(sfcs_pkg::OFS_STAT, 8'h20, 8'h00, "overrun cleared");
		$display("test sync receive done");
		end_sim();
	end
endmodule : test_sfcs_core
